// [hdl/fgr_pkg.sv]
package fgr_pkg;

  // Clock and documented timing figures
  localparam int CLK_PS           = 5000;
  localparam int REFI_BASE_NS_DEF = 7800;
  localparam int RFC1_NS_DEF      = 350;
  localparam int RFC2_NS_DEF      = 260;
  localparam int RFC4_NS_DEF      = 160;

  // Refresh mode field and temperature refresh bit of refresh_config_register
  localparam int       MODE_LSB      = 6;
  localparam int       MODE_MSB      = 8;
  localparam int       TEMP_REF_BIT  = 3;
  localparam logic [2:0] MODE_FIX1   = 3'h0;
  localparam logic [2:0] MODE_FIX2   = 3'h1;
  localparam logic [2:0] MODE_FIX4   = 3'h2;
  localparam logic [2:0] MODE_DYN12  = 3'h5;
  localparam logic [2:0] MODE_DYN14  = 3'h6;
  localparam logic [2:0] MODE_RESET  = 3'h0;

  // Refresh rates
  localparam logic [1:0] RATE_1X = 2'h0;
  localparam logic [1:0] RATE_2X = 2'h1;
  localparam logic [1:0] RATE_4X = 2'h2;

  // Register byte offsets
  localparam logic [3:0] OFS_CFG      = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h4;
  localparam logic [3:0] OFS_FLAGS    = 4'h8;
  localparam logic [3:0] OFS_INTERVAL = 4'hC;

  // Status fields
  localparam int ST_RATE_LSB = 0;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_CNT_LSB  = 3;

  // Sticky flag bits, write one to clear
  localparam int FLAGS_W      = 5;
  localparam int FL_RSV_CODE  = 0;
  localparam int FL_PAR_MODE  = 1;
  localparam int FL_PAR_1X    = 2;
  localparam int FL_CMD_BUSY  = 3;
  localparam int FL_TEMP_MODE = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bg0;
  } ddr_cmd_s;

endpackage

// [hdl/refresh_timer.sv]
`timescale 1ns/1ps
module refresh_timer
  import fgr_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] count
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (load) begin
      count_d = load_val;
    end else if (count_q != '0) begin
      count_d = count_q - W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else if (ce) begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule

// [hdl/fine_refresh.sv]
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fine_refresh
  import fgr_pkg::*;
#(
  parameter int REFI_BASE_NS = REFI_BASE_NS_DEF,
  parameter int RFC1_NS      = RFC1_NS_DEF,
  parameter int RFC2_NS      = RFC2_NS_DEF,
  parameter int RFC4_NS      = RFC4_NS_DEF,
  parameter int ADDR_W       = 4,
  parameter int CNT_W        = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire ddr_cmd_s          cmd,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   refresh_busy,
  output logic [1:0]             refresh_rate,
  output logic [15:0]            avg_refresh_interval
);

  localparam int RFC1_CYC  = (RFC1_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RFC2_CYC  = (RFC2_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RFC4_CYC  = (RFC4_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int REFI1_CYC = (REFI_BASE_NS * 1000) / CLK_PS;
  localparam int REFI2_CYC = (REFI_BASE_NS * 1000) / (2 * CLK_PS);
  localparam int REFI4_CYC = (REFI_BASE_NS * 1000) / (4 * CLK_PS);

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } ref_state_e;

  function automatic logic reserved(input logic [2:0] m);
    return !(m == MODE_FIX1 || m == MODE_FIX2 || m == MODE_FIX4 ||
             m == MODE_DYN12 || m == MODE_DYN14);
  endfunction

  function automatic logic [1:0] mode_rate(input logic [2:0] m);
    case (m)
      MODE_FIX2, MODE_DYN12: mode_rate = RATE_2X;
      MODE_FIX4, MODE_DYN14: mode_rate = RATE_4X;
      default:               mode_rate = RATE_1X;
    endcase
  endfunction

  function automatic logic [1:0] cmd_rate(input logic [2:0] m, input logic bg0);
    if (m[2]) begin
      cmd_rate = bg0 ? mode_rate(m) : RATE_1X;
    end else begin
      cmd_rate = mode_rate(m);
    end
  endfunction

  function automatic logic parity_ok(input logic [1:0] r, input logic [1:0] c);
    case (r)
      RATE_2X: parity_ok = !c[0];
      RATE_4X: parity_ok = (c == 2'h0);
      default: parity_ok = 1'b1;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] rfc_of(input logic [1:0] r);
    case (r)
      RATE_2X: rfc_of = CNT_W'(RFC2_CYC);
      RATE_4X: rfc_of = CNT_W'(RFC4_CYC);
      default: rfc_of = CNT_W'(RFC1_CYC);
    endcase
  endfunction

  function automatic logic [15:0] refi_of(input logic [1:0] r);
    case (r)
      RATE_2X: refi_of = 16'(REFI2_CYC);
      RATE_4X: refi_of = 16'(REFI4_CYC);
      default: refi_of = 16'(REFI1_CYC);
    endcase
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(OFS_CFG) || a == ADDR_W'(OFS_STATUS) ||
           a == ADDR_W'(OFS_FLAGS) || a == ADDR_W'(OFS_INTERVAL);
  endfunction

  ref_state_e          state_q, state_d;
  logic [2:0]          mode_q, mode_d;
  logic                temp_ref_q, temp_ref_d;
  logic [1:0]          rate_q, rate_d;
  logic [1:0]          cnt_q, cnt_d;
  logic [15:0]         refi_q, refi_d;
  logic [FLAGS_W-1:0]  flags_q, flags_d;
  logic                busy_q, busy_d;
  logic                aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0]   waddr_q, waddr_d;
  logic [31:0]         wdat_q, wdat_d;
  logic [3:0]          wstb_q, wstb_d;
  logic                awready_q, awready_d, wready_q, wready_d;
  logic                bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]          bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]         rdata_q, rdata_d;
  logic                is_ref, accept, do_write, tmr_load;
  logic [CNT_W-1:0]    tmr_val, tmr_count;
  logic [31:0]         cfg_word, stat_word, wmerge;
  logic [FLAGS_W-1:0]  set_v, clr_v;
  logic [2:0]          new_mode;
  logic [1:0]          r;

  refresh_timer #(.W(CNT_W)) u_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .load     (tmr_load),
    .load_val (tmr_val),
    .count    (tmr_count)
  );

  assign is_ref   = !cmd.cs_n && cmd.act_n && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
  assign accept   = is_ref && (state_q == ST_IDLE);
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign cfg_word = {23'h0, mode_q, 2'h0, temp_ref_q, 3'h0};
  assign stat_word = {27'h0, cnt_q, busy_q, rate_q};

  always_comb begin
    state_d  = state_q;
    mode_d   = mode_q;
    temp_ref_d = temp_ref_q;
    rate_d   = rate_q;
    cnt_d    = cnt_q;
    refi_d   = refi_q;
    set_v    = '0;
    clr_v    = '0;
    tmr_load = 1'b0;
    tmr_val  = '0;
    r        = cmd_rate(mode_q, cmd.bg0);
    new_mode = mode_q;
    for (int i = 0; i < 32; i++) begin
      wmerge[i] = wstb_q[i/8] ? wdat_q[i] : cfg_word[i];
    end
    if (do_write && waddr_q == ADDR_W'(OFS_CFG)) begin
      new_mode = wmerge[MODE_MSB:MODE_LSB];
      temp_ref_d = wmerge[TEMP_REF_BIT];
      if (reserved(new_mode)) begin
        set_v[FL_RSV_CODE] = 1'b1;
      end else begin
        mode_d = new_mode;
        if (wmerge[TEMP_REF_BIT] && new_mode != MODE_FIX1) begin
          set_v[FL_TEMP_MODE] = 1'b1;
        end
        if (mode_rate(new_mode) != mode_rate(mode_q)) begin
          if (!parity_ok(mode_rate(mode_q), cnt_q)) begin
            set_v[FL_PAR_MODE] = 1'b1;
          end
          cnt_d  = 2'h0;
          refi_d = refi_of(mode_rate(new_mode));
        end
      end
    end
    if (do_write && waddr_q == ADDR_W'(OFS_FLAGS) && wstb_q[0]) begin
      clr_v = wdat_q[FLAGS_W-1:0];
    end
    if (!cmd.cs_n && state_q == ST_BUSY) begin
      set_v[FL_CMD_BUSY] = 1'b1;
    end
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d  = ST_BUSY;
          rate_d   = r;
          refi_d   = refi_of(r);
          tmr_load = 1'b1;
          tmr_val  = rfc_of(r);
          if (r == RATE_1X) begin
            if (mode_q[2] && !parity_ok(mode_rate(mode_q), cnt_q)) begin
              set_v[FL_PAR_1X] = 1'b1;
            end
            cnt_d = 2'h0;
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
      end
      ST_BUSY: begin
        if (tmr_count == CNT_W'(1)) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    busy_d  = (state_d == ST_BUSY);
    flags_d = (flags_q & ~clr_v) | set_v;
  end

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    waddr_d   = waddr_q;
    wdat_d    = wdat_q;
    wstb_d    = wstb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      bvalid_d  = 1'b1;
      bresp_d   = mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
    end
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      waddr_d   = awaddr;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdat_d   = wdata;
      wstb_d   = wstrb;
    end
    if (rvalid_q && rready) begin
      rvalid_d  = 1'b0;
    end
    if (arvalid && arready_q) begin
      rvalid_d  = 1'b1;
      rresp_d   = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        ADDR_W'(OFS_CFG):      rdata_d = cfg_word;
        ADDR_W'(OFS_STATUS):   rdata_d = stat_word;
        ADDR_W'(OFS_FLAGS):    rdata_d = {{(32 - FLAGS_W){1'b0}}, flags_q};
        ADDR_W'(OFS_INTERVAL): rdata_d = {16'h0, refi_q};
        default:               rdata_d = 32'h0;
      endcase
    end
    awready_d = !aw_have_d;
    wready_d  = !w_have_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q   <= ST_IDLE;
      mode_q    <= MODE_RESET;
      temp_ref_q <= 1'b0;
      rate_q    <= RATE_1X;
      cnt_q     <= 2'h0;
      refi_q    <= 16'(REFI1_CYC);
      flags_q   <= '0;
      busy_q    <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= '0;
      wdat_q    <= 32'h0;
      wstb_q    <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0;
    end else if (ce) begin
      state_q   <= state_d;
      mode_q    <= mode_d;
      temp_ref_q <= temp_ref_d;
      rate_q    <= rate_d;
      cnt_q     <= cnt_d;
      refi_q    <= refi_d;
      flags_q   <= flags_d;
      busy_q    <= busy_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      waddr_q   <= waddr_d;
      wdat_q    <= wdat_d;
      wstb_q    <= wstb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  assign awready              = awready_q;
  assign wready               = wready_q;
  assign bvalid               = bvalid_q;
  assign bresp                = bresp_q;
  assign arready              = arready_q;
  assign rvalid               = rvalid_q;
  assign rresp                = rresp_q;
  assign rdata                = rdata_q;
  assign refresh_busy         = busy_q;
  assign refresh_rate         = rate_q;
  assign avg_refresh_interval = refi_q;

  sequence seq_ref_taken;
    ce && accept;
  endsequence

  sequence seq_cfg_write;
    ce && do_write && waddr_q == ADDR_W'(OFS_CFG);
  endsequence

  AST_RFC_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_ref_taken |=> tmr_count == rfc_of(rate_q) && refresh_busy)
    else $error("cycle time not loaded for refresh");
  AST_FIXED_RATE: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_ref_taken ##0 !mode_q[2] |=> refresh_rate == mode_rate($past(mode_q)))
    else $error("fixed mode ran wrong rate");
  AST_DYN_BG0: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_ref_taken ##0 (mode_q == MODE_DYN14 && cmd.bg0) |=> refresh_rate == RATE_4X)
    else $error("bg0 high in 1x/4x mode did not give 4x");
  AST_INTERVAL: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_ref_taken |=> avg_refresh_interval == refi_of(refresh_rate))
    else $error("interval does not follow refresh rate");
  AST_CNT_1X: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_ref_taken ##0 cmd_rate(mode_q, cmd.bg0) == RATE_1X |=> cnt_q == 2'h0)
    else $error("fine counter not cleared by 1x refresh");
  AST_RSV_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_cfg_write ##0 reserved(wmerge[MODE_MSB:MODE_LSB]) |=> $stable(mode_q))
    else $error("reserved code changed refresh mode");
  AST_SAME_RATE: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_cfg_write ##0 !accept ##0 mode_rate(mode_d) == mode_rate(mode_q) |=> $stable(cnt_q))
    else $error("same rate mode swap counted as change");
  AST_CMD_BUSY: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && refresh_busy && !cmd.cs_n |=> flags_q[FL_CMD_BUSY])
    else $error("command during refresh cycle not flagged");
  AST_RATE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    refresh_busy && !(ce && accept) |=> $stable(refresh_rate) [*1])
    else $error("rate changed during refresh cycle");
  AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  AST_AR_FREE: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && rvalid && rready |=> arready && !rvalid)
    else $error("read address not freed after read data taken");

endmodule

// [testbench/ctrl_model.sv]
`timescale 1ns/1ps
module ctrl_model
  import fgr_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic req,
  input  wire logic rate_hi,
  input  wire logic stray,
  input  wire logic busy,
  output ddr_cmd_s  cmd,
  output logic      ack
);
  // Refresh pattern on the control pins, bg0 carries the rate choice
  function automatic ddr_cmd_s ref_cmd(input logic b);
    ref_cmd = '{cs_n: 1'h0, act_n: 1'h1, ras_n: 1'h0, cas_n: 1'h0, we_n: 1'h1, bg0: b};
  endfunction

  always_ff @(posedge aclk) begin
    ack <= 1'h0;
    if (!aresetn) begin
      cmd <= '{cs_n: 1'h1, act_n: 1'h1, ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1, bg0: 1'h0};
    end else if (stray) begin
      cmd <= ref_cmd(1'h0);
    end else if (req && !busy && !ack) begin
      cmd <= ref_cmd(rate_hi);
      ack <= 1'h1;
    end else begin
      // Deselect only; bg0 toggles since it is don't-care here
      cmd <= '{cs_n: 1'h1, act_n: 1'h1, ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1, bg0: ~cmd.bg0};
    end
  end
endmodule

// [testbench/fine_refresh_tb.sv]
`timescale 1ns/1ps
module fine_refresh_tb
  import fgr_pkg::*;
;
  localparam int IV1 = REFI_BASE_NS_DEF * 1000 / CLK_PS;
  logic        aclk = 1'h0, aresetn = 1'h0, req = 1'h0, rate_hi = 1'h0, stray = 1'h0;
  logic        ce = 1'h1;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid, refresh_busy, ack;
  logic [1:0]  bresp, rresp, refresh_rate;
  logic [15:0] avg_refresh_interval;
  ddr_cmd_s    cmd;
  logic [2:0]  rsv [3] = '{3'h3, 3'h4, 3'h7};
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #2.5 aclk = ~aclk;

  fine_refresh i_fine_refresh (
    .aclk, .aresetn, .ce, .cmd, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .refresh_busy, .refresh_rate, .avg_refresh_interval
  );

  ctrl_model i_ctrl_model (
    .aclk, .aresetn, .req, .rate_hi, .stray, .busy(refresh_busy), .cmd, .ack
  );

  function automatic logic [31:0] rfc(input logic [1:0] r);
    int ns;
    ns = r == RATE_1X ? RFC1_NS_DEF : r == RATE_2X ? RFC2_NS_DEF : RFC4_NS_DEF;
    rfc = (ns * 1000 + CLK_PS - 1) / CLK_PS;
  endfunction

  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid && n < 100);
    bready <= 1'h0;
    chk("bresp", {bvalid, bresp}, {1'h1, RESP_OKAY});
  endtask

  task automatic rdr(input logic [3:0] a, input logic [31:0] exp, input string what);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid && n < 100);
    rready <= 1'h0;
    chk(what, {rvalid, rresp, rdata}, {1'h1, RESP_OKAY, exp});
  endtask

  task automatic md(input logic [2:0] m);
    wr(OFS_CFG, 32'(m) << MODE_LSB);
  endtask

  // Read sticky flags, clear them, confirm they are gone
  task automatic flg(input logic [31:0] exp);
    rdr(OFS_FLAGS, exp, "flags");
    wr(OFS_FLAGS, 32'h1F);
    rdr(OFS_FLAGS, 32'h0, "flags_clr");
  endtask

  task automatic dref(input logic hi, input logic [1:0] r, input logic inj);
    int n;
    @(posedge aclk);
    req <= 1'h1;
    rate_hi <= hi;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!ack && n < 100);
    req <= 1'h0;
    @(posedge aclk);
    chk("rate", refresh_rate, r);
    chk("interval", avg_refresh_interval, IV1 >> r);
    n = 0;
    while (refresh_busy === 1'h1 && n < 5000) begin
      n++;
      if (n == 5) stray <= inj;
      if (n == 6) stray <= 1'h0;
      // Freeze three edges with the clock enable: the cycle time stretches by three
      if (n == 10) ce <= !inj;
      if (n == 13) ce <= 1'h1;
      @(posedge aclk);
    end
    chk("busy_len", n, rfc(r) + (inj ? 3 : 0));
    // Space refreshes at the interval of their rate
    repeat ((IV1 >> r) - n) @(posedge aclk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    chk("rst_rate", refresh_rate, RATE_1X);
    chk("rst_busy", refresh_busy, 1'h0);
    rdr(OFS_CFG, 32'(MODE_RESET) << MODE_LSB, "cfg_rst");
    rdr(OFS_INTERVAL, IV1, "iv_rst");
    rdr(OFS_STATUS, 32'h0, "st_rst");
    rdr(OFS_FLAGS, 32'h0, "fl_rst");
    dref(1'h1, RATE_1X, 1'h0);
    md(MODE_FIX2);
    rdr(OFS_INTERVAL, IV1 >> 1, "iv_fix2");
    dref(1'h0, RATE_2X, 1'h0);
    md(MODE_DYN12);
    rdr(OFS_STATUS, (RATE_2X << ST_RATE_LSB) | (1 << ST_CNT_LSB), "st_cnt");
    dref(1'h1, RATE_2X, 1'h0);
    md(MODE_FIX4);
    flg(32'h0);
    dref(1'h0, RATE_4X, 1'h0);
    dref(1'h1, RATE_4X, 1'h0);
    md(MODE_FIX1);
    flg(1 << FL_PAR_MODE);
    md(MODE_FIX2);
    dref(1'h0, RATE_2X, 1'h0);
    md(MODE_FIX1);
    flg(1 << FL_PAR_MODE);
    md(MODE_DYN12);
    dref(1'h0, RATE_1X, 1'h0);
    dref(1'h1, RATE_2X, 1'h0);
    dref(1'h1, RATE_2X, 1'h0);
    dref(1'h0, RATE_1X, 1'h0);
    flg(32'h0);
    dref(1'h1, RATE_2X, 1'h0);
    dref(1'h0, RATE_1X, 1'h0);
    flg(1 << FL_PAR_1X);
    md(MODE_DYN14);
    dref(1'h0, RATE_1X, 1'h0);
    for (int i = 0; i < 4; i++) dref(1'h1, RATE_4X, 1'h0);
    dref(1'h0, RATE_1X, 1'h0);
    flg(32'h0);
    dref(1'h1, RATE_4X, 1'h0);
    dref(1'h1, RATE_4X, 1'h0);
    dref(1'h0, RATE_1X, 1'h0);
    flg(1 << FL_PAR_1X);
    md(MODE_FIX1);
    dref(1'h0, RATE_1X, 1'h1);
    flg(1 << FL_CMD_BUSY);
    foreach (rsv[i]) begin
      md(rsv[i]);
      rdr(OFS_CFG, 32'h0, "cfg_rsv");
      flg(1 << FL_RSV_CODE);
    end
    wr(OFS_CFG, (32'(MODE_FIX2) << MODE_LSB) | (1 << TEMP_REF_BIT));
    flg(1 << FL_TEMP_MODE);
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end
endmodule
